// >>> wkt_pkg.sv
// Package of constants for the low-frequency wakeup timer with compare and capture.
// Summary of operation
// - Radio interrupt edge, when capture enabled, captures timer and sub-tick count.
// - Compare select 11 raises tick on match and resets timer; 0x disables compare.
// - Compare select 10 raises tick on match; timer keeps counting and wraps.
// - Timer-on bit runs the core; when clear the core stops and timer is zero.
// - Compare value from low and high bytes, read/write, both reset to 0xFF.
// - Each capture places timer into read-only low and high capture bytes, reset 0x00.
// - Sub-tick counts MCU cycles since last low-frequency rise; LSB dropped on capture.
// - Sixteen-bit timer starts at zero, counts each low-frequency period; match gives tick.
// - Tick may arrive one low-frequency period late after enable or compare write.
// - Compare value updates at once when either compare byte is written.
// - In retention, wake MCU early; with fast crystal use 49-period pre-start.
// - Short 2-period pre-start with RC only, or crystal already running in retention.
// - With fast RC enabled, MCU runs from it during the pre-start interval.
// - Writing 1 to soft capture trigger captures timer and sub-tick like a radio capture, even with capture disabled.
package wkt_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_CONFIG      = 8'hB3;
  localparam logic [7:0] ADDR_CMP_LOW     = 8'hB4;
  localparam logic [7:0] ADDR_CMP_HIGH    = 8'hB5;
  localparam logic [7:0] ADDR_CAPT_LOW    = 8'hB6;
  localparam logic [7:0] ADDR_CAPT_HIGH   = 8'hAB;
  localparam logic [7:0] ADDR_SUBTICK     = 8'hAC;

  // ==========================================================================
  // Configuration field positions
  localparam int BIT_TIMER_ON     = 0;
  localparam int BIT_CMP_SEL_LO   = 1;
  localparam int BIT_CMP_SEL_HI   = 2;
  localparam int BIT_CAPT_EN      = 3;
  localparam int BIT_SOFT_CAPT    = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_CMP_BYTE  = 8'hFF;
  localparam logic [7:0]  RST_CAPT_BYTE = 8'h00;
  localparam logic [1:0]  RST_CMP_SEL   = 2'h0;
  localparam logic [15:0] RST_TIMER     = 16'h0000;

  // Compare select encodings.
  localparam logic [1:0] CMP_SEL_MATCH       = 2'h2;
  localparam logic [1:0] CMP_SEL_MATCH_RESET = 2'h3;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS      = 100;
  localparam int LF_PERIOD_NS       = 30520;
  // Low-frequency period, rounded down, in MCU cycles.
  localparam int LF_PERIOD_CYCLES   = LF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRESTART_LONG      = 49;
  localparam int PRESTART_SHORT     = 2;
  localparam int SUBTICK_WIDTH      = 9;

endpackage : wkt_pkg

// >>> wkt_sync.sv
// Two-flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module wkt_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } wkt_sync_state_t;

  wkt_sync_state_t state_q;
  wkt_sync_state_t state_d;

  // ==========================================================================
  // Next state
  always_comb begin
    state_d        = state_q;
    state_d.stage1 = asyncIn;
    state_d.stage2 = state_q.stage1;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;

endmodule : wkt_sync

// >>> wkt_subtick.sv
// Counter of MCU clock cycles since the last low-frequency clock rising edge.
`timescale 1ns/1ps
module wkt_subtick
  import wkt_pkg::*;
#(
  parameter int WIDTH = wkt_pkg::SUBTICK_WIDTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Control
  input  wire logic             lfEdge,
  input  wire logic             enable,
  // Count
  output logic      [WIDTH-1:0] count
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } wkt_subtick_state_t;

  wkt_subtick_state_t state_q;
  wkt_subtick_state_t state_d;

  // ==========================================================================
  // Next state
  // The count saturates so a stalled low-frequency clock never wraps it back
  // into a plausible-looking small value.
  always_comb begin
    state_d = state_q;
    if (!enable || lfEdge) begin
      state_d.count = '0;
    end else if (state_q.count != {WIDTH{1'b1}}) begin
      state_d.count = state_q.count + 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign count = state_q.count;

endmodule : wkt_subtick

// >>> wkt_wakeup_timer.sv
// Low-frequency wakeup timer with compare, tick, pre-start and capture.
`timescale 1ns/1ps
module wkt_wakeup_timer
  import wkt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Special-function register port
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic       sfrRdEn,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // Low-frequency clock and radio interrupt, both asynchronous
  input  wire logic       lowFreqClock,
  input  wire logic       radioIrq,
  // Power and clock status
  input  wire logic       retentionMode,
  input  wire logic       fastCrystalOscEnable,
  input  wire logic       fastRcOscEnable,
  input  wire logic       fastCrystalRunInRetention,
  // Outputs to the interrupt and power controllers
  output logic            tickIrq,
  output logic            mcuWake,
  output logic            rcClockSelect
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        timerOn;
    logic [1:0]  compareSelect;
    logic        captureEnable;
    logic [15:0] compareValue;
    logic [15:0] timer;
    logic [15:0] capture;
    logic [7:0]  subtickCapture;
    logic [7:0]  readData;
    logic        lfPrev;
    logic        radioPrev;
    logic        tick;
    logic        wake;
    logic        rcSel;
    logic        crystalWasRunning;
  } wkt_state_t;

  wkt_state_t state_q;
  wkt_state_t state_d;

  // ==========================================================================
  // Synchronisers and sub-tick counter
  logic [1:0]               syncOut;
  logic                     lfSync;
  logic                     radioSync;
  logic                     lfEdge;
  logic                     radioEdge;
  logic [SUBTICK_WIDTH-1:0] subtickCount;

  wkt_sync #(
    .WIDTH   (2)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({radioIrq, lowFreqClock}),
    .syncOut (syncOut)
  );

  assign lfSync    = syncOut[0];
  assign radioSync = syncOut[1];
  assign lfEdge    = lfSync & ~state_q.lfPrev;
  assign radioEdge = radioSync & ~state_q.radioPrev;

  wkt_subtick #(
    .WIDTH   (SUBTICK_WIDTH)
  ) u_subtick (
    .clk     (clk),
    .reset_n (reset_n),
    .lfEdge  (lfEdge),
    .enable  (state_q.timerOn),
    .count   (subtickCount)
  );

  // ==========================================================================
  // Helpers
  function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] target);
    addrHit = (addr == target);
  endfunction : addrHit

  function automatic logic [7:0] readMux(input wkt_state_t s, input logic [7:0] addr);
    logic [7:0] data;
    data = 8'h00;
    if (addrHit(addr, ADDR_CONFIG)) begin
      data[BIT_TIMER_ON]                  = s.timerOn;
      data[BIT_CMP_SEL_HI:BIT_CMP_SEL_LO] = s.compareSelect;
      data[BIT_CAPT_EN]                   = s.captureEnable;
    end else if (addrHit(addr, ADDR_CMP_LOW)) begin
      data = s.compareValue[7:0];
    end else if (addrHit(addr, ADDR_CMP_HIGH)) begin
      data = s.compareValue[15:8];
    end else if (addrHit(addr, ADDR_CAPT_LOW)) begin
      data = s.capture[7:0];
    end else if (addrHit(addr, ADDR_CAPT_HIGH)) begin
      data = s.capture[15:8];
    end else if (addrHit(addr, ADDR_SUBTICK)) begin
      data = s.subtickCapture;
    end
    readMux = data;
  endfunction : readMux

  // ==========================================================================
  // Compare and pre-start decode
  logic        compareActive;
  logic        matchNow;
  logic        softCapture;
  logic        captureEvent;
  logic        longPrestart;
  logic [15:0] prestartLen;
  logic [15:0] remaining;
  logic        prestartHit;

  // Compare select 0x turns the comparator off entirely.
  assign compareActive = state_q.timerOn & state_q.compareSelect[1];
  assign matchNow      = compareActive & (state_q.timer == state_q.compareValue);

  assign softCapture = sfrWrEn & addrHit(sfrAddr, ADDR_CONFIG)
                       & sfrWdata[BIT_SOFT_CAPT];
  assign captureEvent = softCapture
                        | (state_q.captureEnable & radioEdge);

  // The crystal needs the long wait unless it was already up in retention.
  assign longPrestart = fastCrystalOscEnable & ~state_q.crystalWasRunning;
  assign prestartLen  = longPrestart ? 16'(PRESTART_LONG)
                                     : 16'(PRESTART_SHORT);
  assign remaining    = 16'(state_q.compareValue - state_q.timer);
  assign prestartHit  = compareActive & retentionMode & (remaining == prestartLen);

  // ==========================================================================
  // Next state
  always_comb begin
    state_d           = state_q;
    state_d.lfPrev    = lfSync;
    state_d.radioPrev = radioSync;
    state_d.tick      = 1'b0;

    // Register writes. The compare value takes effect byte by byte with no
    // staging, so a half-written pair may match early; software masks the
    // tick around the two writes.
    if (sfrWrEn) begin
      if (addrHit(sfrAddr, ADDR_CONFIG)) begin
        state_d.timerOn       = sfrWdata[BIT_TIMER_ON];
        state_d.compareSelect = sfrWdata[BIT_CMP_SEL_HI:BIT_CMP_SEL_LO];
        state_d.captureEnable = sfrWdata[BIT_CAPT_EN];
      end
      if (addrHit(sfrAddr, ADDR_CMP_LOW)) begin
        state_d.compareValue[7:0] = sfrWdata;
      end
      if (addrHit(sfrAddr, ADDR_CMP_HIGH)) begin
        state_d.compareValue[15:8] = sfrWdata;
      end
    end

    // Timer core, advanced only on low-frequency edges. Because a start or
    // compare change waits for the next edge, it lands up to one low-frequency
    // period later than written.
    if (!state_q.timerOn) begin
      state_d.timer = RST_TIMER;
      state_d.wake  = 1'b0;
    end else if (lfEdge) begin
      if (matchNow) begin
        state_d.tick = 1'b1;
        if (state_q.compareSelect == CMP_SEL_MATCH_RESET) begin
          state_d.timer = RST_TIMER;
        end else begin
          state_d.timer = state_q.timer + 16'h0001;
        end
      end else begin
        state_d.timer = state_q.timer + 16'h0001;
      end
    end

    // MCU pre-start: raised ahead of the tick while in retention, dropped
    // in the same cycle that the tick is raised.
    if (state_q.timerOn && lfEdge) begin
      if (prestartHit) begin
        state_d.wake = 1'b1;
      end else if (matchNow) begin
        state_d.wake = 1'b0;
      end
    end
    state_d.rcSel = state_d.wake & fastRcOscEnable;

    // Remember whether the crystal ran on entry to retention.
    if (!retentionMode) begin
      state_d.crystalWasRunning = fastCrystalRunInRetention & fastCrystalOscEnable;
    end

    // Capture; registers change only here, never on a read.
    if (captureEvent) begin
      state_d.capture        = state_q.timer;
      state_d.subtickCapture = subtickCount[SUBTICK_WIDTH-1:1];
    end

    // Reads only update the registered read data.
    if (sfrRdEn) begin
      state_d.readData = readMux(state_q, sfrAddr);
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q                   <= '0;
      state_q.compareSelect     <= RST_CMP_SEL;
      state_q.compareValue      <= {RST_CMP_BYTE, RST_CMP_BYTE};
      state_q.capture           <= {RST_CAPT_BYTE, RST_CAPT_BYTE};
      state_q.subtickCapture    <= RST_CAPT_BYTE;
      state_q.timer             <= RST_TIMER;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign sfrRdata      = state_q.readData;
  assign tickIrq       = state_q.tick;
  assign mcuWake       = state_q.wake;
  assign rcClockSelect = state_q.rcSel;

endmodule : wkt_wakeup_timer

// >>> wkt_lf_source.sv
// Low-frequency clock source model feeding the wakeup timer.
`timescale 1ns/1ps
module wkt_lf_source (
  // Clock out
  output logic lowFreqClock
);
  initial lowFreqClock = 1'b0;
  // The source runs free from time zero, so it is up before the timer is enabled.
  always #(wkt_pkg::LF_PERIOD_NS / 2) lowFreqClock = ~lowFreqClock;
endmodule : wkt_lf_source

// >>> wkt_wakeup_timer_asserts.sv
// Port-level checker for the wakeup timer.
`timescale 1ns/1ps
module wkt_wakeup_timer_asserts
  import wkt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  // Outside world
  input wire logic lowFreqClock,
  input wire logic radioIrq,
  input wire logic retentionMode,
  input wire logic fastCrystalOscEnable,
  input wire logic fastRcOscEnable,
  input wire logic fastCrystalRunInRetention,
  input wire logic tickIrq,
  input wire logic mcuWake,
  input wire logic rcClockSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic mapped;
  logic cfgWr;
  assign mapped = sfrAddr inside {ADDR_CONFIG, ADDR_CMP_LOW, ADDR_CMP_HIGH, ADDR_CAPT_LOW,
                                  ADDR_CAPT_HIGH, ADDR_SUBTICK};
  assign cfgWr = sfrWrEn && sfrAddr == ADDR_CONFIG;
  // ==========================================================================
  // Register port
  sequence s_cmpWr; sfrWrEn && sfrAddr == ADDR_CMP_LOW; endsequence
  sequence s_cmpRd; sfrRdEn && sfrAddr == ADDR_CMP_LOW; endsequence
  property p_cmpBack; s_cmpWr ##1 s_cmpRd |=> sfrRdata == $past(sfrWdata, 2); endproperty
  a_cmpBack: assert property (p_cmpBack) else $error("compare byte read back wrong");
  property p_unmapped; sfrRdEn && !mapped |=> sfrRdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; !sfrRdEn |=> $stable(sfrRdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_trigRd; sfrRdEn && sfrAddr == ADDR_CONFIG |=> !sfrRdata[BIT_SOFT_CAPT]; endproperty
  a_trigRd: assert property (p_trigRd) else $error("capture trigger reads as one");
  // ==========================================================================
  // Tick and wake
  property p_tick; tickIrq |-> lowFreqClock && !$past(lowFreqClock, 8) ##1 !tickIrq; endproperty
  a_tick: assert property (p_tick) else $error("tick not a pulse after a slow edge");
  property p_wake; $rose(mcuWake) |-> lowFreqClock && !$past(lowFreqClock, 8); endproperty
  a_wake: assert property (p_wake) else $error("wake rose away from a slow edge");
  property p_retWake; tickIrq && retentionMode |-> $past(mcuWake, 2); endproperty
  a_retWake: assert property (p_retWake) else $error("tick in retention without wake");
  property p_noTick;
    cfgWr && !(sfrWdata[BIT_TIMER_ON] && sfrWdata[BIT_CMP_SEL_HI]) |=> ##1 (!tickIrq) [*4];
  endproperty
  a_noTick: assert property (p_noTick) else $error("tick while compare is off");
  property p_offWake; cfgWr && !sfrWdata[BIT_TIMER_ON] |-> ##3 !mcuWake; endproperty
  a_offWake: assert property (p_offWake) else $error("wake held with timer stopped");
  property p_rcSel; rcClockSelect |-> fastRcOscEnable && (mcuWake || $past(mcuWake)); endproperty
  a_rcSel: assert property (p_rcSel) else $error("rc select outside wake");
endmodule : wkt_wakeup_timer_asserts

bind wkt_wakeup_timer wkt_wakeup_timer_asserts u_chk (.clk, .reset_n, .sfrAddr, .sfrWrEn,
  .sfrRdEn, .sfrWdata, .sfrRdata, .lowFreqClock, .radioIrq, .retentionMode,
  .fastCrystalOscEnable, .fastRcOscEnable, .fastCrystalRunInRetention, .tickIrq, .mcuWake,
  .rcClockSelect);

// >>> wkt_wakeup_timer_bench.sv
// Self-checking testbench for the wakeup timer.
`timescale 1ns/1ps
module wkt_wakeup_timer_bench;
  import wkt_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrEn = 1'b0;
  logic sfrRdEn = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic lowFreqClock;
  logic radioIrq = 1'b0;
  logic retentionMode = 1'b0;
  logic fastCrystalOscEnable = 1'b0;
  logic fastRcOscEnable = 1'b0;
  logic fastCrystalRunInRetention = 1'b0;
  logic tickIrq;
  logic mcuWake;
  logic rcClockSelect;
  int errorCnt = 0;
  int checks = 0;
  int n;
  int w;

  always #50 clk = ~clk;
  wkt_lf_source u_lf (.lowFreqClock);
  wkt_wakeup_timer u_dut (.clk, .reset_n, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWdata, .sfrRdata,
    .lowFreqClock, .radioIrq, .retentionMode, .fastCrystalOscEnable, .fastRcOscEnable,
    .fastCrystalRunInRetention, .tickIrq, .mcuWake, .rcClockSelect);

  // ==========================================================================
  // Access tasks
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rng(input string name, input int v, input int e);
    chk(name, 16'(v > e - 4 && v < e + 4), 16'h0001);
  endtask : rng
  task automatic pause(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask : pause
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrEn = 1'b1;
    pause(1);
    sfrWrEn = 1'b0;
  endtask : wr
  task automatic rdRaw(input logic [7:0] a);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    pause(1);
    sfrRdEn = 1'b0;
    pause(1);
  endtask : rdRaw
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] e);
    rdRaw(a);
    chk(name, {8'h00, sfrRdata}, {8'h00, e});
  endtask : rd
  // Counts cycles to the next tick and, within them, cycles with the wake request up.
  task automatic tk(output int n, output int w);
    n = 0;
    w = 0;
    while (tickIrq !== 1'b1 && n < 20000) begin
      if (mcuWake === 1'b1) w++;
      if (w > 2 && mcuWake === 1'b1) chk("rcSel", rcClockSelect, fastRcOscEnable);
      pause(1);
      n++;
    end
    chk("tickSeen", tickIrq, 1'b1);
    pause(1);
  endtask : tk
  task automatic radio();
    radioIrq = 1'b1;
    pause(4);
    radioIrq = 1'b0;
  endtask : radio
  task summarize;
    $display("checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // ==========================================================================
  // Tests
  initial begin
    pause(3);
    reset_n = 1'b1;
    rd("cfg", ADDR_CONFIG, 8'h00);
    rd("cmpLow", ADDR_CMP_LOW, 8'hFF);
    rd("cmpHigh", ADDR_CMP_HIGH, 8'hFF);
    rd("captLow", ADDR_CAPT_LOW, 8'h00);
    rd("captHigh", ADDR_CAPT_HIGH, 8'h00);
    rd("subtick", ADDR_SUBTICK, 8'h00);
    rd("unmapped", 8'hB7, 8'h00);
    wr(ADDR_CAPT_LOW, 8'h5A);
    rd("captRo", ADDR_CAPT_LOW, 8'h00);
    wr(ADDR_CMP_HIGH, 8'h00);
    rd("cmpHighRw", ADDR_CMP_HIGH, 8'h00);
    wr(ADDR_CMP_LOW, 8'h03);
    rd("cmpLowRw", ADDR_CMP_LOW, 8'h03);
    wr(ADDR_CONFIG, 8'h10);
    rd("cfgTrig", ADDR_CONFIG, 8'h00);
    rd("captOff", ADDR_CAPT_LOW, 8'h00);
    wr(ADDR_CONFIG, 8'h07);
    tk(n, w);
    tk(n, w);
    rng("period11", n, 4 * LF_PERIOD_NS / CLK_PERIOD_NS);
    pause(455);
    wr(ADDR_CONFIG, 8'h17);
    rd("capt11", ADDR_CAPT_LOW, 8'h01);
    rd("captHi", ADDR_CAPT_HIGH, 8'h00);
    // The sub-tick count depends on the slow clock phase, so only its range is exact.
    rdRaw(ADDR_SUBTICK);
    chk("sub11", 16'(sfrRdata != 8'h00), 16'h0001);
    rng("subRange", int'(sfrRdata), (458 - LF_PERIOD_CYCLES) / 2);
    wr(ADDR_CMP_LOW, 8'h01);
    rd("cmpNow", ADDR_CMP_LOW, 8'h01);
    tk(n, w);
    tk(n, w);
    rng("period1", n, 2 * LF_PERIOD_NS / CLK_PERIOD_NS);
    wr(ADDR_CONFIG, 8'h05);
    tk(n, w);
    pause(455);
    wr(ADDR_CONFIG, 8'h15);
    rd("capt10", ADDR_CAPT_LOW, 8'h03);
    wr(ADDR_CONFIG, 8'h00);
    pause(1);
    wr(ADDR_CONFIG, 8'h07);
    tk(n, w);
    pause(400);
    radio();
    rd("radioOff", ADDR_CAPT_LOW, 8'h03);
    wr(ADDR_CONFIG, 8'h0F);
    tk(n, w);
    pause(400);
    radio();
    rd("radioOn", ADDR_CAPT_LOW, 8'h01);
    wr(ADDR_CMP_LOW, 8'h05);
    retentionMode = 1'b1;
    fastRcOscEnable = 1'b1;
    tk(n, w);
    rng("preShort", w, 2 * LF_PERIOD_NS / CLK_PERIOD_NS);
    fastCrystalOscEnable = 1'b1;
    fastRcOscEnable = 1'b0;
    wr(ADDR_CMP_LOW, 8'h3C);
    tk(n, w);
    rng("preLong", w, 49 * LF_PERIOD_NS / CLK_PERIOD_NS);
    // Leave retention with the crystal set to keep running, then go back in.
    retentionMode = 1'b0;
    fastCrystalRunInRetention = 1'b1;
    pause(2);
    retentionMode = 1'b1;
    wr(ADDR_CMP_LOW, 8'h05);
    tk(n, w);
    rng("preWarm", w, 2 * LF_PERIOD_NS / CLK_PERIOD_NS);
    summarize();
  end

  // The tests need about 30,000 cycles; the watchdog allows 100,000.
  initial begin
    #10_000_000;
    errorCnt++;
    summarize();
  end
endmodule : wkt_wakeup_timer_bench
